// *** rtl/fir_eq_cfg.svh ***
// address map, field positions, reset values and sizes of the fir equalizer
`ifndef FIR_EQ_CFG_SVH
`define FIR_EQ_CFG_SVH
`define ADDR_W            12
`define OFS_CFG           12'h400
`define OFS_TAP0          12'h418
`define OFS_TAP1          12'h41a
`define OFS_TAP2          12'h41c
`define OFS_TAP3          12'h41e
`define OFS_CENTRE        12'h420
`define OFS_TAP5          12'h423
`define OFS_TAP6          12'h425
`define OFS_TAP7          12'h427
`define OFS_TAP8          12'h429
`define OFS_LINK          12'h200
`define OFS_STATUS        12'h201
`define MODE_LSB          0
`define MODE_MSB          1
`define SCW_LSB           2
`define SCW_MSB           4
`define MERGE_BIT         5
`define SHARE_BIT         6
`define CFG_RESET         8'h00
`define COEF_RESET        12'h000
`define CENTRE_RESET      18'h00000
`define SCW_MAX           3'h6
`define SIDE_FRAC         16
`define CENTRE_FRAC       16
`define NUM_TAPS          9
`define CENTRE_IDX        4
`define FIFO_DEPTH        8
`endif

// *** rtl/fir_eq_pkg.sv ***
// types shared by the fir equalizer files
package fir_eq_pkg;
  typedef enum logic [1:0] {
    MODE_BYPASS = 2'h0,
    MODE_RSVD1  = 2'h1,
    MODE_ENABLE = 2'h2,
    MODE_RSVD3  = 2'h3
  } filter_mode_t;
  typedef struct packed {
    logic         reserved;
    logic         channel_b_reuse_coefs;
    logic         combine_filters;
    logic [2:0]   side_coef_weight;
    filter_mode_t filter_mode_select;
  } filter_cfg_t;
  typedef struct packed {
    logic [11:0] addr;
    logic [23:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;
  typedef logic signed [11:0] sample_t;
endpackage : fir_eq_pkg

// *** rtl/sample_fifo.sv ***
// parameterised valid/ready fifo for the sample path
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr_reg;
  logic [AW-1:0]    rptr_reg;
  logic [AW:0]      count_reg;
  wire              push;
  wire              pop;
  // honest flags straight from the occupancy count
  assign in_ready  = (count_reg < (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rptr_reg];
  // storage has no reset; only pointers and count need a defined value
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wptr_reg] <= in_data;
    end
  end
  // pointers and count
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wptr_reg  <= '0;
      rptr_reg  <= '0;
      count_reg <= '0;
    end else begin
      if (push) wptr_reg <= (wptr_reg == AW'(DEPTH-1)) ? '0 : wptr_reg + 1'b1;
      if (pop) rptr_reg <= (rptr_reg == AW'(DEPTH-1)) ? '0 : rptr_reg + 1'b1;
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sample_fifo
`default_nettype wire

// *** rtl/fir_equalizer.sv ***
// programmable 9-tap fir equalizer with register file and output fifo
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "fir_eq_cfg.svh"
// What this block does
// R1: side tap lsb is worth two to the power side weight minus sixteen.
// R2: side weight scales every tap except the centre tap.
// R3: side weight is three bits, values 0 to 6 only.
// R4: side weight resets to zero, lsb worth two to minus sixteen.
// R5: mode 0 bypasses, mode 2 filters, codes 1 and 3 reserved.
// R6: software loads coefficients whenever it enables the filter.
// R7: software changes settings only while the output link is disabled.
// R8: first four taps are signed 12-bit in bits 11:0, upper bits zero.
// R9: registers 0 to 3 feed taps one to four of the channel a filter.
// R10: share set makes channel b use channel a coefficients.
// R11: merge makes one filter over an interleaved stream.
// R12: nine taps, fifth is the 18-bit signed centre tap.
// R13: enabled output is sum of nine scaled products; bypass passes through.
module fir_equalizer
  import fir_eq_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic [11:0]       reg_addr,
  input  wire logic [23:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [23:0]            reg_rdata,
  input  wire fir_eq_pkg::sample_t a_in,
  input  wire fir_eq_pkg::sample_t b_in,
  input  wire logic              in_valid,
  output logic                   in_ready,
  output logic [23:0]            out_data,
  output logic                   out_valid,
  input  wire logic              out_ready,
  output logic                   output_link_enable
);
  import fir_eq_pkg::*;

  localparam int N = `NUM_TAPS;
  filter_cfg_t       cfg_reg;
  logic [11:0]       coef_a_reg [N];
  logic [11:0]       coef_b_reg [N];
  logic [17:0]       centre_a_reg;
  logic [17:0]       centre_b_reg;
  logic              link_reg;
  logic              cfg_violation_reg;
  logic [23:0]       rdata_reg;
  sample_t           hist_a_reg [N];
  sample_t           hist_b_reg [N];
  logic [11:0]       y_a_reg;
  logic [11:0]       y_b_reg;
  logic              y_valid_reg;
  logic              fifo_in_ready;

  // address decode, one helper so tap decodes stay uniform
  function automatic logic [4:0] tap_index(input logic [11:0] a);
    case (a)
      `OFS_TAP0:   tap_index = 5'h00;
      `OFS_TAP1:   tap_index = 5'h01;
      `OFS_TAP2:   tap_index = 5'h02;
      `OFS_TAP3:   tap_index = 5'h03;
      `OFS_CENTRE: tap_index = 5'h04;
      `OFS_TAP5:   tap_index = 5'h05;
      `OFS_TAP6:   tap_index = 5'h06;
      `OFS_TAP7:   tap_index = 5'h07;
      `OFS_TAP8:   tap_index = 5'h08;
      default:     tap_index = 5'h1f;
    endcase
  endfunction : tap_index

  // channel b set lives at the a offset plus 0x100
  wire [11:0] b_addr    = reg_addr - 12'h100;
  wire [4:0]  idx_a     = tap_index(reg_addr);
  wire [4:0]  idx_b     = tap_index(b_addr);
  wire        hit_cfg   = (reg_addr == `OFS_CFG);
  wire        hit_link  = (reg_addr == `OFS_LINK);
  wire        hit_stat  = (reg_addr == `OFS_STATUS);
  wire        hit_a     = (idx_a != 5'h1f);
  wire        hit_b     = (idx_b != 5'h1f);
  // a settings write while the link runs is flagged, not blocked
  wire        set_wr    = reg_wr && (hit_cfg || hit_a || hit_b);
  wire        violation = set_wr && link_reg; // R7
  wire [2:0]  scw_in    = reg_wdata[`SCW_MSB:`SCW_LSB];
  wire        scw_ok    = (scw_in <= `SCW_MAX); // R3

  // configuration and link control
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_reg  <= filter_cfg_t'(`CFG_RESET); // R4 R5
      link_reg <= 1'b0;
    end else begin
      if (reg_wr && hit_cfg) begin
        // an oversized weight is clamped so the shifter stays in range
        cfg_reg <= filter_cfg_t'({1'b0, reg_wdata[6:5],
                                  scw_ok ? scw_in : `SCW_MAX, reg_wdata[1:0]}); // R3
      end
      if (reg_wr && hit_link) link_reg <= reg_wdata[0];
    end
  end

  // sticky violation flag; a new violation beats a clearing write
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_violation_reg <= 1'b0;
    end else if (violation) begin
      cfg_violation_reg <= 1'b1;
    end else if (reg_wr && hit_stat && reg_wdata[0]) begin
      cfg_violation_reg <= 1'b0;
    end
  end

  // coefficient storage; the centre taps keep their own 18-bit registers
  genvar t;
  generate
    for (t = 0; t < N; t++) begin : g_coef
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          coef_a_reg[t] <= `COEF_RESET;
          coef_b_reg[t] <= `COEF_RESET;
        end else begin
          if (reg_wr && idx_a == 5'(t)) coef_a_reg[t] <= reg_wdata[11:0]; // R8 R9
          if (reg_wr && idx_b == 5'(t)) coef_b_reg[t] <= reg_wdata[11:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      centre_a_reg <= `CENTRE_RESET;
      centre_b_reg <= `CENTRE_RESET;
    end else begin
      if (reg_wr && idx_a == 5'(`CENTRE_IDX)) centre_a_reg <= reg_wdata[17:0]; // R12
      if (reg_wr && idx_b == 5'(`CENTRE_IDX)) centre_b_reg <= reg_wdata[17:0];
    end
  end

  // read mux; reserved bits read zero, unmapped reads zero
  wire [23:0] rd_a = (idx_a == 5'(`CENTRE_IDX)) ? {6'h00, centre_a_reg}
                   : {12'h000, coef_a_reg[idx_a[3:0]]}; // R8
  wire [23:0] rd_b = (idx_b == 5'(`CENTRE_IDX)) ? {6'h00, centre_b_reg}
                   : {12'h000, coef_b_reg[idx_b[3:0]]};
  wire [23:0] rd_mux = hit_cfg  ? {16'h0000, cfg_reg}
                     : hit_link ? {23'h000000, link_reg}
                     : hit_stat ? {23'h000000, cfg_violation_reg}
                     : hit_a    ? rd_a
                     : hit_b    ? rd_b
                     : 24'h000000;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) rdata_reg <= 24'h000000;
    else if (reg_rd) rdata_reg <= rd_mux;
  end
  assign reg_rdata          = rdata_reg;
  assign output_link_enable = link_reg;

  // sample history; fifo back-pressure stalls the whole pipeline
  wire advance = in_valid && fifo_in_ready;
  assign in_ready = fifo_in_ready;

  generate
    for (t = 0; t < N; t++) begin : g_hist
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          hist_a_reg[t] <= '0;
          hist_b_reg[t] <= '0;
        end else if (advance) begin
          hist_a_reg[t] <= (t == 0) ? a_in : hist_a_reg[t == 0 ? 0 : t-1];
          hist_b_reg[t] <= (t == 0) ? b_in : hist_b_reg[t == 0 ? 0 : t-1];
        end
      end
    end
  endgenerate

  // the window starts with the sample being taken, so each word belongs to its own input
  sample_t win_a [N];
  sample_t win_b [N];
  generate
    for (t = 0; t < N; t++) begin : g_win
      if (t == 0) begin : g_new
        assign win_a[t] = a_in;
        assign win_b[t] = b_in;
      end else begin : g_old
        assign win_a[t] = hist_a_reg[t-1];
        assign win_b[t] = hist_b_reg[t-1];
      end
    end
  endgenerate

  // merged mode walks one interleaved stream: b,a,b,a newest first
  function automatic logic signed [11:0] merged_tap(input int k,
                                                   input sample_t ha [N],
                                                   input sample_t hb [N]);
    merged_tap = (k % 2 == 0) ? hb[k/2] : ha[k/2];
  endfunction : merged_tap

  // coefficient in 2^-16 units; side taps shifted by weight, centre fixed
  function automatic logic signed [23:0] tap_val(input int k,
                                                input logic [11:0] side [N],
                                                input logic [17:0] ctr,
                                                input logic [2:0] scw);
    logic signed [23:0] s;
    s = 24'(signed'(side[k]));
    if (k == `CENTRE_IDX) tap_val = 24'(signed'(ctr)); // R2 R12
    else tap_val = s <<< scw; // R1
  endfunction : tap_val

  logic signed [47:0] acc_a;
  logic signed [47:0] acc_b;
  always_comb begin
    acc_a = '0;
    acc_b = '0;
    for (int k = 0; k < N; k++) begin
      // share picks channel a coefficients for channel b
      acc_a = acc_a + 48'(signed'(cfg_reg.combine_filters
                ? merged_tap(k, win_a, win_b) : win_a[k]))
                * 48'(tap_val(k, coef_a_reg, centre_a_reg, cfg_reg.side_coef_weight)); // R13 R11
      acc_b = acc_b + 48'(signed'(cfg_reg.combine_filters
                ? merged_tap(k+1, win_a, win_b) : win_b[k]))
                * 48'(cfg_reg.channel_b_reuse_coefs
                  ? tap_val(k, coef_a_reg, centre_a_reg, cfg_reg.side_coef_weight)
                  : tap_val(k, coef_b_reg, centre_b_reg, cfg_reg.side_coef_weight)); // R10
    end
  end

  // saturate the 2^-16 scaled sum back to a 12-bit sample
  function automatic logic [11:0] sat12(input logic signed [47:0] v);
    logic signed [47:0] q;
    q = v >>> `SIDE_FRAC;
    if (q > 48'sd2047) sat12 = 12'h7ff;
    else if (q < -48'sd2048) sat12 = 12'h800;
    else sat12 = q[11:0];
  endfunction : sat12

  wire filtering = (cfg_reg.filter_mode_select == MODE_ENABLE); // R5
  wire [11:0] ya_next = filtering ? sat12(acc_a) : win_a[0]; // R13
  wire [11:0] yb_next = filtering ? sat12(acc_b) : win_b[0];
  // merged mode takes the same undelayed acc_b sum; b sees the newest a through its window
  wire [11:0] yb_sel = (filtering && cfg_reg.combine_filters) ? sat12(acc_b) : yb_next;

  // output stage: one word per accepted input, one cycle later
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      y_a_reg     <= 12'h000;
      y_b_reg     <= 12'h000;
      y_valid_reg <= 1'b0;
    end else begin
      y_valid_reg <= advance;
      if (advance) begin
        y_a_reg <= ya_next;
        y_b_reg <= yb_sel;
      end
    end
  end

  // output fifo; the pipeline's stall term comes from occ_reg below, not from its ready
  wire fifo_push_ready;
  sample_fifo #(
    .WIDTH (24),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .in_data   ({y_b_reg, y_a_reg}),
    .in_valid  (y_valid_reg),
    .in_ready  (fifo_push_ready),
    .out_data  (out_data),
    .out_valid (out_valid),
    .out_ready (out_ready)
  );
  // keep one slot spare for the word already in the output stage
  logic [3:0] occ_reg;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) occ_reg <= 4'h0;
    else occ_reg <= occ_reg + 4'(y_valid_reg && fifo_push_ready) - 4'(out_valid && out_ready);
  end
  assign fifo_in_ready = (occ_reg + 4'(y_valid_reg)) < 4'(`FIFO_DEPTH);

  // assertions
  property p_scw_range;
    @(posedge sys_clk) disable iff (sys_rst) cfg_reg.side_coef_weight <= 3'h6;
  endproperty
  a_scw_range: assert property (p_scw_range) else $error("side weight above 6"); // R3
  property p_read_one_cycle;
    @(posedge sys_clk) disable iff (sys_rst)
      reg_rd |=> (reg_rdata == $past(rd_mux));
  endproperty
  a_read_one_cycle: assert property (p_read_one_cycle) else $error("read data wrong"); // R8
  property p_coef_reserved_zero;
    @(posedge sys_clk) disable iff (sys_rst)
      (reg_rd && hit_a && idx_a != 5'h04) |=> (reg_rdata[23:12] == 12'h000);
  endproperty
  a_coef_reserved_zero: assert property (p_coef_reserved_zero) else $error("rsvd"); // R8
  property p_coef_write;
    @(posedge sys_clk) disable iff (sys_rst)
      (reg_wr && reg_addr == `OFS_TAP0) |=> (coef_a_reg[0] == $past(reg_wdata[11:0]));
  endproperty
  a_coef_write: assert property (p_coef_write) else $error("tap0 not stored"); // R9
  property p_bypass;
    @(posedge sys_clk) disable iff (sys_rst)
      (advance && !filtering) |=> (y_a_reg == $past(a_in));
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass altered sample"); // R5
  property p_violation;
    @(posedge sys_clk) disable iff (sys_rst) violation |=> cfg_violation_reg;
  endproperty
  a_violation: assert property (p_violation) else $error("violation lost"); // R7
  property p_out_valid;
    @(posedge sys_clk) disable iff (sys_rst) advance |=> y_valid_reg;
  endproperty
  a_out_valid: assert property (p_out_valid) else $error("output missed"); // R13
  property p_no_overflow;
    @(posedge sys_clk) disable iff (sys_rst) y_valid_reg |-> fifo_push_ready;
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("fifo overflow"); // R13
  // a taken word reaches the output stage, then the fifo, on the next two edges
  sequence s_sample_taken;
    advance;
  endsequence
  sequence s_word_queued;
    y_valid_reg ##1 out_valid;
  endsequence
  property p_sample_to_fifo;
    @(posedge sys_clk) disable iff (sys_rst) s_sample_taken |=> s_word_queued;
  endproperty
  a_sample_to_fifo: assert property (p_sample_to_fifo) else $error("sample not queued"); // R13
  property p_bypass_b;
    @(posedge sys_clk) disable iff (sys_rst)
      (advance && !filtering) |=> (y_b_reg == $past(b_in));
  endproperty
  a_bypass_b: assert property (p_bypass_b) else $error("bypass altered b sample"); // R5
  // a stalled head word must not move or vanish
  property p_head_holds;
    @(posedge sys_clk) disable iff (sys_rst)
      (out_valid && !out_ready) |=> (out_valid && $stable(out_data));
  endproperty
  a_head_holds: assert property (p_head_holds) else $error("stalled word changed"); // R13
  // read data stand until the next read strobe
  property p_rdata_holds;
    @(posedge sys_clk) disable iff (sys_rst) !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rdata_holds: assert property (p_rdata_holds) else $error("read data moved"); // R8
endmodule : fir_equalizer
`default_nettype wire

// *** verification/tb.sv ***
// self-checking bench for the fir equalizer: registers, bypass, taps, link guard, fifo
`timescale 1ns/1ps
`default_nettype none
`include "fir_eq_cfg.svh"
module tb;
  import fir_eq_pkg::*;
  logic        sys_clk;
  logic        sys_rst;
  logic [11:0] reg_addr;
  logic [23:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [23:0] reg_rdata;
  sample_t     a_in;
  sample_t     b_in;
  logic        in_valid;
  logic        in_ready;
  logic [23:0] out_data;
  logic        out_valid;
  logic        out_ready;
  logic        output_link_enable;
  int          error_cnt;
  int          cmp_count;
  logic [23:0] got[$];
  logic [11:0] taps[4] = '{`OFS_TAP0, `OFS_TAP1, `OFS_TAP2, `OFS_TAP3};

  fir_equalizer i_dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .a_in(a_in), .b_in(b_in),
    .in_valid(in_valid), .in_ready(in_ready), .out_data(out_data), .out_valid(out_valid),
    .out_ready(out_ready), .output_link_enable(output_link_enable)
  );

  // clock at 10 MHz
  initial sys_clk = 1'b0;
  always #50 sys_clk = ~sys_clk;

  // collect every word popped from the output fifo
  always @(posedge sys_clk) begin
    if (!sys_rst && out_valid === 1'b1 && out_ready === 1'b1) got.push_back(out_data);
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    cmp_count++;
    if (g !== e) begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      error_cnt++;
    end
  endtask : chk

  task automatic expired();
    chk(24'h0, 24'h1);
    complete_run();
  endtask : expired

  // one-cycle write strobe beside address and data
  task automatic wr(input logic [11:0] a, input logic [23:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data load at the edge that samples the strobe and stand until the next strobe, so look just past that edge
  task automatic rd_chk(input logic [11:0] a, input logic [23:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd_chk

  // hold the sample until an edge where in_ready was high
  task automatic push(input logic [11:0] a, input logic [11:0] b);
    logic ok = 1'b0;
    int   n  = 0;
    @(posedge sys_clk);
    a_in     <= a;
    b_in     <= b;
    in_valid <= 1'b1;
    while (!ok && n < 50) begin
      @(negedge sys_clk);
      ok = (in_ready === 1'b1);
      @(posedge sys_clk);
      n++;
    end
    in_valid <= 1'b0;
    if (!ok) expired();
  endtask : push

  task automatic wait_out(input int n);
    int k = 0;
    while (got.size() < n && k < 300) begin
      @(posedge sys_clk);
      k++;
    end
    if (got.size() < n) expired();
  endtask : wait_out

  task automatic t_reset();
    rd_chk(`OFS_CFG, 24'h000000);
    foreach (taps[i]) rd_chk(taps[i], 24'h000000);
    $display("reset values done");
  endtask : t_reset

  task automatic t_regs();
    logic [23:0] v[4] = '{24'h000800, 24'h0007ff, 24'h000abc, 24'h000001};
    foreach (taps[i]) wr(taps[i], v[i]);
    foreach (taps[i]) rd_chk(taps[i], v[i]);
    wr(12'h401, 24'h0000ff);
    rd_chk(12'h401, 24'h000000);
    wr(`OFS_CFG, 24'h00001c);
    rd_chk(`OFS_CFG, 24'h000018);
    wr(`OFS_CFG, 24'h000018);
    rd_chk(`OFS_CFG, 24'h000018);
    $display("register file done");
  endtask : t_regs

  // reserved codes must not filter; both channels pass unchanged
  task automatic t_bypass();
    logic [11:0] av;
    for (int m = 0; m < 4; m++) begin
      if (m == 2) continue;
      av = 12'h123 + 12'(m);
      wr(`OFS_CFG, 24'(m));
      got.delete();
      push(av, 12'hfed);
      wait_out(1);
      chk(got[0], {12'hfed, av});
    end
    $display("bypass done");
  endtask : t_bypass

  // expected output when a 1024 impulse sits on tap k; taps past the centre are zero
  function automatic int imp_exp(input int k, input int w, input int c[4]);
    imp_exp = (k < 4) ? ((1024 * c[k % 4]) >>> (16 - w)) : ((k == 4) ? 1024 : 0);
  endfunction : imp_exp

  // impulse through every tap; b shares a's set, centre ignores the side weight;
  // merged, b is the even and a the odd sample of one stream, b's window starts at a
  task automatic t_impulse(input int w, input int mg);
    int c[4] = '{256, -512, 2047, -2048};
    int ea;
    int eb;
    wr(`OFS_CFG, 24'(32'h42 | (w << 2) | (mg << 5)));
    foreach (taps[i]) wr(taps[i], 24'(c[i]) & 24'h000fff);
    wr(`OFS_CENTRE, 24'h010000);
    repeat (9) push(12'h000, 12'h000);
    repeat (6) @(posedge sys_clk);
    got.delete();
    push(12'h400, (mg != 0) ? 12'h000 : 12'h400);
    repeat (8) push(12'h000, 12'h000);
    wait_out(9);
    for (int k = 0; k < 9; k++) begin
      ea = imp_exp((mg != 0) ? 2 * k + 1 : k, w, c);
      eb = imp_exp((mg != 0) ? 2 * k : k, w, c);
      chk(got[k], {12'(eb), 12'(ea)});
    end
    $display("impulse with side weight %0d merge %0d done", w, mg);
  endtask : t_impulse

  task automatic t_link();
    wr(`OFS_LINK, 24'h000001);
    #1 chk({23'h0, output_link_enable}, 24'h000001);
    wr(`OFS_CFG, 24'h000000);
    rd_chk(`OFS_STATUS, 24'h000001);
    wr(`OFS_LINK, 24'h000000);
    wr(`OFS_STATUS, 24'h000001);
    rd_chk(`OFS_STATUS, 24'h000000);
    chk({23'h0, output_link_enable}, 24'h000000);
    $display("link guard done");
  endtask : t_link

  // stall the far side, fill until refused, then drain in order
  task automatic t_fifo();
    logic ok;
    int   acc  = 0;
    int   idle = 0;
    got.delete();
    @(posedge sys_clk);
    out_ready <= 1'b0;
    a_in      <= 12'h000;
    b_in      <= 12'h000;
    in_valid  <= 1'b1;
    while (idle < 4 && acc < 40) begin
      @(negedge sys_clk);
      ok = (in_ready === 1'b1);
      @(posedge sys_clk);
      if (ok) begin
        acc++;
        a_in <= 12'(acc);
        b_in <= 12'(acc);
        idle = 0;
      end else idle++;
    end
    in_valid <= 1'b0;
    chk(24'(acc >= `FIFO_DEPTH && acc < 40), 24'h1);
    out_ready <= 1'b1;
    wait_out(acc);
    repeat (4) @(posedge sys_clk);
    chk(24'(got.size()), 24'(acc));
    foreach (got[i]) chk(got[i], {12'(i), 12'(i)});
    $display("fifo fill and drain done");
  endtask : t_fifo

  initial begin
    sys_rst   = 1'b1;
    reg_addr  = 12'h000;
    reg_wdata = 24'h000000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    a_in      = 12'h000;
    b_in      = 12'h000;
    in_valid  = 1'b0;
    out_ready = 1'b1;
    error_cnt = 0;
    cmp_count = 0;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_regs();
    t_bypass();
    t_impulse(0, 0);
    t_impulse(2, 0);
    t_impulse(6, 0);
    t_impulse(0, 1);
    t_link();
    t_fifo();
    complete_run();
  end
endmodule : tb
`default_nettype wire
